// File: common/iau_pkg.sv
// Operation
// RULE1: Plain add writes first plus second source; no flags change.
// RULE2: Record form of plain add updates the sign field only.
// RULE3: Overflow form without record updates wrap and sticky, not sign field.
// RULE4: Overflow form with record updates wrap, sticky and sign field together.
// RULE5: Carrying and extended basic forms update only the carry bit.
// RULE6: Carrying or extended record forms update carry and sign field.
// RULE7: Carrying or extended overflow forms update carry, wrap, sticky; sign if recording.
// RULE8: Immediate add uses sign-extended immediate plus source or zero; no flags.
// RULE9: Carrying immediate add always updates carry; sign field when recording; no overflow.
// RULE10: Shifted immediate add uses immediate above sixteen zeros; no flags.
// RULE11: Extended add sums both sources plus the current carry bit.
// RULE12: Minus-one add sums source, current carry and all ones.
// RULE13: Zero-extended add sums source and current carry; no second operand.
// RULE14: Carry bit is held between adds so wide sums can be chained.
// RULE15: Updated carry bit is the carry out of the top result bit.
// RULE16: Wrap set also sets sticky; only a register move clears sticky.
// RULE17: Sign field comes from a signed compare of the result against zero.
// RULE18: Two's-complement add modulo two to the 32; result same across variants.
package iau_pkg;

  // ==========================================================================
  // Widths and operation codes
  // ==========================================================================
  localparam int unsigned DATA_W = 32;
  localparam int unsigned IMM_W = 16;
  localparam int unsigned GPR_IDX_W = 5;
  localparam int unsigned APB_ADDR_W = 8;

  typedef enum logic [2:0] {
    IAU_OP_PLAIN,
    IAU_OP_CARRYING,
    IAU_OP_IMM,
    IAU_OP_IMM_CARRY,
    IAU_OP_IMM_SHIFT,
    IAU_OP_EXTENDED,
    IAU_OP_MINUS_ONE,
    IAU_OP_ZERO_EXT
  } iau_op_t;

  // ==========================================================================
  // Request from decode and answer to the register file
  // ==========================================================================
  typedef struct packed {
    logic valid;
    iau_op_t op;
    logic record;
    logic ovf_en;
    logic base_zero;
    logic [GPR_IDX_W-1:0] dest;
    logic [DATA_W-1:0] src_a;
    logic [DATA_W-1:0] src_b;
    logic [IMM_W-1:0] imm;
  } iau_req_t;

  typedef struct packed {
    logic valid;
    logic [GPR_IDX_W-1:0] dest;
    logic [DATA_W-1:0] value;
  } iau_resp_t;

  // ==========================================================================
  // Register map and field layout
  // ==========================================================================
  localparam logic [APB_ADDR_W-1:0] OFS_EXC = 8'h00;
  localparam logic [APB_ADDR_W-1:0] OFS_SIGN = 8'h04;
  localparam logic [APB_ADDR_W-1:0] OFS_LAST = 8'h08;
  localparam logic [APB_ADDR_W-1:0] OFS_COUNT = 8'h0C;

  localparam int unsigned EXC_COUT_POS = 0;
  localparam int unsigned EXC_WRAP_POS = 1;
  localparam int unsigned EXC_STICKY_POS = 2;

  localparam int unsigned SIGN_LT_POS = 3;
  localparam int unsigned SIGN_GT_POS = 2;
  localparam int unsigned SIGN_EQ_POS = 1;
  localparam int unsigned SIGN_SO_POS = 0;

  localparam logic RST_COUT = 1'b0;
  localparam logic RST_WRAP = 1'b0;
  localparam logic RST_STICKY = 1'b0;
  localparam logic [3:0] RST_SIGN = 4'h0;
  localparam logic [DATA_W-1:0] RST_WORD = 32'h0000_0000;
  localparam logic [DATA_W-1:0] ALL_ONES = 32'hFFFF_FFFF;
  localparam logic [IMM_W-1:0] SHIFT_FILL = 16'h0000;

endpackage : iau_pkg

// File: rtl/iau_adder_core.sv
`timescale 1ns/1ns
// ============================================================================
// Three-input adder with carry out and signed wrap detection
// ============================================================================
module iau_adder_core #(
  parameter int unsigned WIDTH = 32
) (
  input wire logic [WIDTH-1:0] opnd_a,
  input wire logic [WIDTH-1:0] opnd_b,
  input wire logic carry_in,
  output logic [WIDTH-1:0] sum,
  output logic carry_out,
  output logic wrap
);

  logic [WIDTH:0] full;
  logic [WIDTH-1:0] low;

  // The carry into the top bit is recovered from the lower slice so that
  // wrap is true only when the carries into and out of the top bit differ.
  always_comb
  begin
    full = {1'b0, opnd_a} + {1'b0, opnd_b} + {{WIDTH{1'b0}}, carry_in}; // RULE18
    low = {1'b0, opnd_a[WIDTH-2:0]} + {1'b0, opnd_b[WIDTH-2:0]}
      + {{(WIDTH-1){1'b0}}, carry_in};
    sum = full[WIDTH-1:0];
    carry_out = full[WIDTH]; // RULE15
    wrap = low[WIDTH-1] ^ full[WIDTH];
  end

endmodule : iau_adder_core

// File: rtl/iau_add_unit.sv
// Our own choices: the APB register port and the register addresses.
`timescale 1ns/1ns
// ============================================================================
// Integer addition unit with its exception bits, sign field and APB access
// ============================================================================
module iau_add_unit (
  input wire logic clk_sys,
  input wire logic srst,
  input wire iau_pkg::iau_req_t req,
  output iau_pkg::iau_resp_t resp,
  output logic arith_cout_bit,
  output logic signed_wrap_flag,
  output logic sticky_wrap_flag,
  output logic [3:0] result_sign_field,
  input wire logic [iau_pkg::APB_ADDR_W-1:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr
);

  // ==========================================================================
  // Operation decode helpers
  // ==========================================================================
  // Operations that write the carry bit.
  function automatic logic op_sets_carry(input iau_pkg::iau_op_t op);
    op_sets_carry = !(op == iau_pkg::IAU_OP_PLAIN || op == iau_pkg::IAU_OP_IMM
      || op == iau_pkg::IAU_OP_IMM_SHIFT);
  endfunction : op_sets_carry

  // Immediate forms have no overflow variant; only carrying immediate records.
  function automatic logic op_is_imm(input iau_pkg::iau_op_t op);
    op_is_imm = (op == iau_pkg::IAU_OP_IMM || op == iau_pkg::IAU_OP_IMM_CARRY
      || op == iau_pkg::IAU_OP_IMM_SHIFT);
  endfunction : op_is_imm

  function automatic logic op_uses_cin(input iau_pkg::iau_op_t op);
    op_uses_cin = (op == iau_pkg::IAU_OP_EXTENDED || op == iau_pkg::IAU_OP_MINUS_ONE
      || op == iau_pkg::IAU_OP_ZERO_EXT);
  endfunction : op_uses_cin

  // ==========================================================================
  // Operand selection
  // ==========================================================================
  logic [31:0] opnd_a;
  logic [31:0] opnd_b;
  logic cin;
  logic [31:0] sum;
  logic cout;
  logic wrap;
  logic [31:0] imm_sext;
  logic cout_q;

  // The base is forced to zero only for the two non-carrying immediate forms;
  // the carrying immediate always takes the first source as given.
  always_comb
  begin
    imm_sext = {{16{req.imm[15]}}, req.imm};
    opnd_a = req.src_a;
    if ((req.op == iau_pkg::IAU_OP_IMM || req.op == iau_pkg::IAU_OP_IMM_SHIFT)
        && req.base_zero)
    begin
      opnd_a = iau_pkg::RST_WORD; // RULE8 RULE10
    end
    case (req.op)
      iau_pkg::IAU_OP_PLAIN: opnd_b = req.src_b; // RULE1
      iau_pkg::IAU_OP_CARRYING: opnd_b = req.src_b;
      iau_pkg::IAU_OP_IMM: opnd_b = imm_sext; // RULE8
      iau_pkg::IAU_OP_IMM_CARRY: opnd_b = imm_sext; // RULE9
      iau_pkg::IAU_OP_IMM_SHIFT: opnd_b = {req.imm, iau_pkg::SHIFT_FILL}; // RULE10
      iau_pkg::IAU_OP_EXTENDED: opnd_b = req.src_b; // RULE11
      iau_pkg::IAU_OP_MINUS_ONE: opnd_b = iau_pkg::ALL_ONES; // RULE12
      iau_pkg::IAU_OP_ZERO_EXT: opnd_b = iau_pkg::RST_WORD; // RULE13
      default: opnd_b = req.src_b;
    endcase
    cin = op_uses_cin(req.op) ? cout_q : 1'b0; // RULE14
  end

  iau_adder_core #(
    .WIDTH(iau_pkg::DATA_W)
  ) u_core (
    .opnd_a(opnd_a),
    .opnd_b(opnd_b),
    .carry_in(cin),
    .sum(sum),
    .carry_out(cout),
    .wrap(wrap)
  );

  // ==========================================================================
  // Exception bits, sign field and result
  // ==========================================================================
  logic cout_d;
  logic wrap_q;
  logic wrap_d;
  logic sticky_q;
  logic sticky_d;
  logic [3:0] sign_q;
  logic [3:0] sign_d;
  iau_pkg::iau_resp_t resp_q;
  iau_pkg::iau_resp_t resp_d;
  logic [31:0] count_q;
  logic [31:0] count_d;
  logic upd_cout;
  logic upd_wrap;
  logic upd_sign;
  logic exc_wr;

  // A register move to the exception word lands first; an add in the same
  // cycle then overrides the bits it owns, and a fresh wrap always sets the
  // sticky bit so that an overflow racing the clear is never lost.
  always_comb
  begin
    exc_wr = psel && penable && pwrite && (paddr == iau_pkg::OFS_EXC) && pstrb[0];
    upd_cout = req.valid && op_sets_carry(req.op); // RULE5 RULE9
    upd_wrap = req.valid && req.ovf_en && !op_is_imm(req.op); // RULE3 RULE7 RULE9
    upd_sign = req.valid && req.record
      && (req.op != iau_pkg::IAU_OP_IMM) && (req.op != iau_pkg::IAU_OP_IMM_SHIFT); // RULE2
    cout_d = exc_wr ? pwdata[iau_pkg::EXC_COUT_POS] : cout_q;
    wrap_d = exc_wr ? pwdata[iau_pkg::EXC_WRAP_POS] : wrap_q;
    sticky_d = exc_wr ? pwdata[iau_pkg::EXC_STICKY_POS] : sticky_q;
    if (upd_cout)
    begin
      cout_d = cout; // RULE15 RULE14
    end
    if (upd_wrap)
    begin
      wrap_d = wrap; // RULE3 RULE4 RULE7
      sticky_d = sticky_d | wrap; // RULE16
    end
    sign_d = sign_q;
    if (upd_sign)
    begin
      sign_d[iau_pkg::SIGN_LT_POS] = sum[31]; // RULE17 RULE4 RULE6
      sign_d[iau_pkg::SIGN_GT_POS] = !sum[31] && (sum != iau_pkg::RST_WORD);
      sign_d[iau_pkg::SIGN_EQ_POS] = (sum == iau_pkg::RST_WORD);
      sign_d[iau_pkg::SIGN_SO_POS] = sticky_d;
    end
    resp_d.valid = req.valid;
    resp_d.dest = req.dest;
    resp_d.value = req.valid ? sum : resp_q.value; // RULE18
    count_d = req.valid ? count_q + 32'h0000_0001 : count_q;
  end

  always_ff @(posedge clk_sys)
  begin
    if (srst)
    begin
      cout_q <= iau_pkg::RST_COUT;
      wrap_q <= iau_pkg::RST_WRAP;
      sticky_q <= iau_pkg::RST_STICKY;
      sign_q <= iau_pkg::RST_SIGN;
      resp_q <= '0;
      count_q <= iau_pkg::RST_WORD;
    end
    else
    begin
      cout_q <= cout_d;
      wrap_q <= wrap_d;
      sticky_q <= sticky_d;
      sign_q <= sign_d;
      resp_q <= resp_d;
      count_q <= count_d;
    end
  end

  // Outputs come straight from the state flops.
  assign resp = resp_q;
  assign arith_cout_bit = cout_q;
  assign signed_wrap_flag = wrap_q;
  assign sticky_wrap_flag = sticky_q;
  assign result_sign_field = sign_q;

  // ==========================================================================
  // APB slave
  // ==========================================================================
  logic [31:0] prdata_q;
  logic [31:0] prdata_d;
  logic pslverr_q;
  logic pslverr_d;
  logic mapped;

  // Read data is captured in the setup phase, so the access phase always
  // completes at once with data from a flop; reads return state as it stood
  // at the setup edge.
  always_comb
  begin
    mapped = (paddr == iau_pkg::OFS_EXC) || (paddr == iau_pkg::OFS_SIGN)
      || (paddr == iau_pkg::OFS_LAST) || (paddr == iau_pkg::OFS_COUNT);
    prdata_d = prdata_q;
    pslverr_d = pslverr_q;
    if (psel && !penable)
    begin
      pslverr_d = !mapped || (pwrite && paddr != iau_pkg::OFS_EXC);
      prdata_d = iau_pkg::RST_WORD;
      if (!pwrite)
      begin
        case (paddr)
          iau_pkg::OFS_EXC: prdata_d = {29'h0000_0000, sticky_q, wrap_q, cout_q};
          iau_pkg::OFS_SIGN: prdata_d = {28'h000_0000, sign_q};
          iau_pkg::OFS_LAST: prdata_d = resp_q.value;
          iau_pkg::OFS_COUNT: prdata_d = count_q;
          default: prdata_d = iau_pkg::RST_WORD;
        endcase
      end
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (srst)
    begin
      prdata_q <= iau_pkg::RST_WORD;
      pslverr_q <= 1'b0;
    end
    else
    begin
      prdata_q <= prdata_d;
      pslverr_q <= pslverr_d;
    end
  end

  // The slave never stalls, so every access phase ends at its first edge.
  assign pready = 1'b1;
  assign prdata = prdata_q;
  assign pslverr = pslverr_q;

  // ==========================================================================
  // Assertions and coverage
  // ==========================================================================
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (srst);

  chk_plain_sum: assert property ( // RULE1
    req.valid && req.op == iau_pkg::IAU_OP_PLAIN && !exc_wr
    |=> resp.valid && resp.value == $past(req.src_a + req.src_b)
      && $stable(arith_cout_bit))
    else $error("Plain add result or carry wrong.");

  chk_record_only: assert property ( // RULE2
    req.valid && req.op == iau_pkg::IAU_OP_PLAIN && req.record && !req.ovf_en && !exc_wr
    |=> $stable(signed_wrap_flag) && $stable(sticky_wrap_flag)
      && result_sign_field[iau_pkg::SIGN_LT_POS] == resp.value[31])
    else $error("Record add touched exception bits or sign wrong.");

  chk_ovf_no_sign: assert property ( // RULE3
    req.valid && req.ovf_en && !req.record
    |=> $stable(result_sign_field))
    else $error("Sign field changed without record.");

  chk_wrap_sets_sticky: assert property ( // RULE16
    req.valid && req.ovf_en && !op_is_imm(req.op)
      && (req.src_a[31] == req.src_b[31]) && req.op == iau_pkg::IAU_OP_PLAIN
      && ((req.src_a + req.src_b) >> 31) != {31'h0000_0000, req.src_a[31]}
    |=> signed_wrap_flag && sticky_wrap_flag)
    else $error("Overflow did not set wrap and sticky.");

  chk_sticky_hold: assert property ( // RULE16
    sticky_wrap_flag && !exc_wr |=> sticky_wrap_flag)
    else $error("Sticky wrap cleared by an add.");

  chk_imm_zero_base: assert property ( // RULE8
    req.valid && req.op == iau_pkg::IAU_OP_IMM && req.base_zero
    |=> resp.value == {{16{$past(req.imm[15])}}, $past(req.imm)})
    else $error("Immediate add with zero base wrong.");

  chk_imm_shift: assert property ( // RULE10
    req.valid && req.op == iau_pkg::IAU_OP_IMM_SHIFT && !req.base_zero && !exc_wr
    |=> resp.value == $past(req.src_a + {req.imm, 16'h0000}) && $stable(arith_cout_bit))
    else $error("Shifted immediate add wrong.");

  chk_extend_sum: assert property ( // RULE11
    req.valid && req.op == iau_pkg::IAU_OP_EXTENDED
    |=> resp.value == $past(req.src_a + req.src_b + {31'h0000_0000, arith_cout_bit}))
    else $error("Extended add ignored the carry.");

  chk_minus_one: assert property ( // RULE12
    req.valid && req.op == iau_pkg::IAU_OP_MINUS_ONE && arith_cout_bit
    |=> resp.value == $past(req.src_a))
    else $error("Minus-one add with carry set must return the source.");

  chk_carry_out: assert property ( // RULE15
    req.valid && req.op == iau_pkg::IAU_OP_CARRYING
    |=> arith_cout_bit == $past(({1'b0, req.src_a} + {1'b0, req.src_b}) >> 32))
    else $error("Carry bit is not the carry out of the top bit.");

  cov_wide_chain: cover property (
    req.valid && req.op == iau_pkg::IAU_OP_CARRYING
    ##1 req.valid && req.op == iau_pkg::IAU_OP_EXTENDED && arith_cout_bit);
  cov_ovf_record: cover property (req.valid && req.ovf_en && req.record ##1 signed_wrap_flag);
  cov_clear_race: cover property (exc_wr && upd_wrap && wrap);

endmodule : iau_add_unit

// File: tb/iau_dec_model.sv
`timescale 1ns/1ns
// ============================================================================
// Decode pipeline and register file standing in front of the adder
// ============================================================================
module iau_dec_model (
  input wire logic clk_sys,
  output iau_pkg::iau_req_t req,
  input wire iau_pkg::iau_resp_t resp
);
  logic [31:0] gpr_q [32];

  // Nothing is requested until the first issue call.
  initial req = '0;

  // Write back every answered sum into the register file.
  always @(posedge clk_sys)
  begin
    if (resp.valid === 1'b1)
      gpr_q[resp.dest] <= resp.value;
  end

  // One request, held for exactly one edge, then the fields are scrambled.
  // Scrambling keeps a design that reads stale fields from passing by luck.
  task automatic issue(input iau_pkg::iau_op_t op, input logic rec, ov, bz,
                       input logic [4:0] dst, input logic [31:0] a, b,
                       input logic [15:0] imm);
    iau_pkg::iau_req_t t;
    @(posedge clk_sys);
    req <= '{valid:1'b1, op:op, record:rec, ovf_en:ov, base_zero:bz, dest:dst,
             src_a:a, src_b:b, imm:imm};
    @(posedge clk_sys);
    t = ~req;
    t.valid = 1'b0;
    req <= t;
  endtask : issue
endmodule : iau_dec_model

// File: tb/integer_addition_unit_tb.sv
`timescale 1ns/1ns
// ============================================================================
// Self-checking bench for the addition unit
// ============================================================================
module integer_addition_unit_tb;
  logic clk_sys;
  logic srst;
  iau_pkg::iau_req_t req;
  iau_pkg::iau_resp_t resp;
  logic arith_cout_bit;
  logic signed_wrap_flag;
  logic sticky_wrap_flag;
  logic [3:0] result_sign_field;
  logic [7:0] paddr;
  logic psel;
  logic penable;
  logic pwrite;
  logic [31:0] pwdata;
  logic [3:0] pstrb;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  int n_mismatch = 0;
  int comparisons = 0;
  int cycles = 0;
  int n_req = 0;
  logic exp_c = 1'b0;
  logic exp_w = 1'b0;
  logic exp_s = 1'b0;
  logic [3:0] exp_sg = 4'h0;
  logic [31:0] last_val = 32'h0;
  logic [31:0] rd;
  logic err;
  logic [31:0] va [4] = '{32'h7FFF_FFFF, 32'hFFFF_FFFF, 32'h8000_0000, 32'h0000_0005};
  logic [31:0] vb [4] = '{32'h0000_0001, 32'h0000_0001, 32'h8000_0000, 32'hFFFF_FFFB};
  logic [15:0] vi [4] = '{16'h7FFF, 16'h0001, 16'h8000, 16'hFFFB};

  iau_add_unit i_dut (.clk_sys(clk_sys), .srst(srst), .req(req), .resp(resp),
    .arith_cout_bit(arith_cout_bit), .signed_wrap_flag(signed_wrap_flag),
    .sticky_wrap_flag(sticky_wrap_flag), .result_sign_field(result_sign_field),
    .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
    .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr));

  iau_dec_model i_part (.clk_sys(clk_sys), .req(req), .resp(resp));

  // ==========================================================================
  // Clock and hang guard
  // ==========================================================================
  initial
  begin
    clk_sys = 1'b0;
    forever #50 clk_sys = ~clk_sys;
  end

  // About 300 cycles are needed; the ceiling leaves wide margin.
  always @(posedge clk_sys)
  begin
    cycles++;
    if (cycles == 5000)
    begin
      n_mismatch++;
      give_verdict();
    end
  end

  // ==========================================================================
  // Compare, bus and operation tasks
  // ==========================================================================
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  // Setup cycle, then access phase held until pready is seen high.
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                     input logic [3:0] st);
    @(posedge clk_sys);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    pstrb <= st;
    @(posedge clk_sys);
    penable <= 1'b1;
    @(posedge clk_sys);
    while (pready !== 1'b1) @(posedge clk_sys);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  // Works out the expected sum and flags, issues the request, compares.
  task automatic step(input int o, input logic rec, ov, bz,
                      input logic [31:0] a, b, input logic [15:0] imm);
    iau_pkg::iau_op_t op;
    logic [31:0] x;
    logic [31:0] y;
    logic [32:0] s;
    logic ci;
    logic immz;
    op = iau_pkg::iau_op_t'(o);
    immz = (op == iau_pkg::IAU_OP_IMM) || (op == iau_pkg::IAU_OP_IMM_SHIFT);
    x = (bz && immz) ? 32'h0000_0000 : a;
    case (op)
      iau_pkg::IAU_OP_IMM, iau_pkg::IAU_OP_IMM_CARRY: y = {{16{imm[15]}}, imm};
      iau_pkg::IAU_OP_IMM_SHIFT: y = {imm, iau_pkg::SHIFT_FILL};
      iau_pkg::IAU_OP_MINUS_ONE: y = iau_pkg::ALL_ONES;
      iau_pkg::IAU_OP_ZERO_EXT: y = 32'h0000_0000;
      default: y = b;
    endcase
    ci = (o >= 5) ? exp_c : 1'b0;
    s = {1'b0, x} + {1'b0, y} + {32'h0000_0000, ci};
    i_part.issue(op, rec, ov, bz, 5'(o), a, b, imm);
    n_req++;
    last_val = s[31:0];
    if (!immz && op != iau_pkg::IAU_OP_PLAIN)
      exp_c = s[32];
    if (ov && !immz && op != iau_pkg::IAU_OP_IMM_CARRY)
    begin
      exp_w = (x[31] == y[31]) && (s[31] != x[31]);
      exp_s = exp_s | exp_w;
    end
    if (rec && !immz)
      exp_sg = {$signed(s[31:0]) < 0, $signed(s[31:0]) > 0, s[31:0] == 0, exp_s};
    #1;
    chk({31'h0, resp.valid}, 32'h1);
    chk({27'h0, resp.dest}, 32'(o));
    chk(resp.value, s[31:0]);
    chk({31'h0, arith_cout_bit}, {31'h0, exp_c});
    chk({30'h0, signed_wrap_flag, sticky_wrap_flag}, {30'h0, exp_w, exp_s});
    chk({28'h0, result_sign_field}, {28'h0, exp_sg});
  endtask : step

  task automatic give_verdict();
    $display("mismatches=%0d comparisons=%0d", n_mismatch, comparisons);
    if (n_mismatch == 0 && comparisons > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : give_verdict

  // ==========================================================================
  // Main sequence
  // ==========================================================================
  initial
  begin
    srst = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
    pstrb = 4'h0;
    repeat (12) @(posedge clk_sys);
    srst <= 1'b0;
    apb(1'b0, iau_pkg::OFS_EXC, 32'h0, 4'h0);
    chk(rd, 32'h0000_0000);
    // Every operation with every flag variant; carry chains across steps.
    for (int v = 0; v < 4; v++)
      for (int o = 0; o < 8; o++)
        for (int k = 0; k < 4; k++)
          step(o, k[0], k[1], v[0], va[v], vb[v], vi[v]);
    // A low-word carrying add followed at once by the high-word extended add.
    step(1, 1'b0, 1'b0, 1'b0, 32'hFFFF_FFFF, 32'h0000_0001, 16'h0000);
    step(5, 1'b0, 1'b0, 1'b0, 32'h0000_0001, 32'h0000_0002, 16'h0000);
    apb(1'b0, iau_pkg::OFS_LAST, 32'h0, 4'h0);
    chk(rd, last_val);
    // The high word of the chained sum must have reached the register file.
    chk(i_part.gpr_q[5], last_val);
    apb(1'b0, iau_pkg::OFS_COUNT, 32'h0, 4'h0);
    chk(rd, 32'(n_req));
    apb(1'b0, iau_pkg::OFS_SIGN, 32'h0, 4'h0);
    chk(rd, {28'h0, exp_sg});
    // A masked write leaves the bits alone; a full write clears sticky.
    apb(1'b1, iau_pkg::OFS_EXC, 32'h0, 4'h0);
    apb(1'b0, iau_pkg::OFS_EXC, 32'h0, 4'h0);
    chk(rd, {29'h0, exp_s, exp_w, exp_c});
    apb(1'b1, iau_pkg::OFS_EXC, 32'h0, 4'hF);
    chk({31'h0, err}, 32'h0);
    apb(1'b0, iau_pkg::OFS_EXC, 32'h0, 4'h0);
    chk(rd, 32'h0000_0000);
    apb(1'b1, iau_pkg::OFS_SIGN, 32'h5, 4'hF);
    chk({31'h0, err}, 32'h1);
    apb(1'b0, 8'h10, 32'h0, 4'h0);
    chk({err, rd[30:0]}, 32'h8000_0000);
    give_verdict();
  end
endmodule : integer_addition_unit_tb
